// File: hw/rotate_subtract_sleep_exec.v
// Rotate, subtract and sleep executor with an AXI4-Lite register port
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "rss_exec_map.vh"
module rotate_subtract_sleep_exec (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        wake_event,
  input  wire        watchdog_tick,
  output reg  [7:0]  watchdog_counter,
  output reg         core_sleeping,
  output reg         file_we,
  output reg  [6:0]  file_addr,
  output reg  [7:0]  file_wdata,
  output reg         acc_we,
  output reg  [7:0]  acc_wdata
);

  // ------------------------------------------------------------------
  // State and storage
  // ------------------------------------------------------------------
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [1:0] ST_SLEEP = 2'b10;

  reg  [1:0]  state_q;
  reg  [31:0] oper_q;
  reg         carry_q;
  reg         nibble_carry_flag;
  reg         zero_q;
  reg         powerdown_status_bit;
  reg         timeout_status_bit;
  reg         done_q;
  reg  [7:0]  result_q;
  reg  [7:0]  presc_q;

  reg         aw_have_q;
  reg  [3:0]  aw_addr_q;
  reg         w_have_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  wire [7:0]  f_val  = oper_q[`OPER_FILE_MSB:`OPER_FILE_LSB];
  wire [7:0]  w_val  = oper_q[`OPER_ACC_MSB:`OPER_ACC_LSB];
  wire [7:0]  k_val  = oper_q[`OPER_LIT_MSB:`OPER_LIT_LSB];
  wire [2:0]  opc    = oper_q[`OPER_OP_MSB:`OPER_OP_LSB];
  wire        dsel   = oper_q[`OPER_DEST_BIT];
  wire [6:0]  faddr  = {3'b000, oper_q[`OPER_ADDR_LSB+3:`OPER_ADDR_LSB]};

  // ------------------------------------------------------------------
  // Opcode decode
  // ------------------------------------------------------------------
  wire        is_lsub  = (opc == `OP_LSUB);
  wire        is_fsubb = (opc == `OP_FSUBB);

  // ------------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------------
  reg  [7:0]  sub_a;
  reg         sub_cin;
  wire [7:0]  sub_diff;
  wire        sub_c;
  wire        sub_dc;

  always @* begin
    sub_a   = f_val;
    sub_cin = 1'b1;
    if (is_lsub) begin
      sub_a = k_val;
    end
    if (is_fsubb) begin
      sub_cin = carry_q;
    end
  end

  sub_unit u_sub (
    .a     (sub_a),
    .b     (w_val),
    .cin   (sub_cin),
    .diff  (sub_diff),
    .cout  (sub_c),
    .dcout (sub_dc)
  );

  wire [7:0] rot_val = {carry_q, f_val[7:1]};

  // ------------------------------------------------------------------
  // Watchdog prescaler
  // ------------------------------------------------------------------
  reg  [7:0]  presc_d;
  reg  [7:0]  wd_d;

  // Counter steps when the prescaler wraps
  always @* begin
    presc_d = presc_q;
    wd_d    = watchdog_counter;
    if (watchdog_tick) begin
      presc_d = presc_q + 8'h01;
      if (presc_q == 8'hFF) begin
        wd_d = watchdog_counter + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  wire        do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire        go_wr    = do_write && (aw_addr_q == `REG_CTRL) &&
                         w_strb_q[0] && w_data_q[`CTRL_GO_BIT];
  wire        wake_wr  = do_write && (aw_addr_q == `REG_CTRL) &&
                         w_strb_q[0] && w_data_q[`CTRL_WAKE_BIT];
  wire        go_exec  = go_wr && (state_q == ST_RUN);
  wire [7:0]  stat_rd  = {1'b0, done_q, state_q == ST_SLEEP,
                          timeout_status_bit, powerdown_status_bit,
                          zero_q, nibble_carry_flag, carry_q};
  wire        oper_wr  = do_write && (aw_addr_q == `REG_OPER);
  wire        bad_wr   = (aw_addr_q != `REG_OPER) &&
                         (aw_addr_q != `REG_CTRL);
  localparam [31:0] OPER_RST = `RST_OPER;
  genvar      g;

  // ------------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= bad_wr ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Operand register byte lanes
  // ------------------------------------------------------------------
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_oper_lane
      always @(posedge aclk) begin
        if (!aresetn) begin
          oper_q[g*8 +: 8] <= OPER_RST[g*8 +: 8];
        end else if (oper_wr && w_strb_q[g]) begin
          oper_q[g*8 +: 8] <= w_data_q[g*8 +: 8];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `REG_CTRL:   s_axi_rdata <= 32'h00000000;
          `REG_OPER:   s_axi_rdata <= oper_q;
          `REG_STATUS: s_axi_rdata <= {24'h000000, stat_rd};
          `REG_RESULT: s_axi_rdata <= {24'h000000, result_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Execution
  // ------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q              <= ST_RUN;
      carry_q              <= 1'b0;
      nibble_carry_flag    <= 1'b0;
      zero_q               <= 1'b0;
      powerdown_status_bit <= 1'b1;
      timeout_status_bit   <= 1'b1;
      done_q               <= 1'b0;
      result_q             <= 8'h00;
      presc_q              <= `RST_PRESC;
      watchdog_counter     <= `RST_WDT;
      core_sleeping        <= 1'b0;
      file_we              <= 1'b0;
      file_addr            <= 7'h00;
      file_wdata           <= 8'h00;
      acc_we               <= 1'b0;
      acc_wdata            <= 8'h00;
    end else begin
      file_we <= 1'b0;
      acc_we  <= 1'b0;
      presc_q          <= presc_d;
      watchdog_counter <= wd_d;
      if (go_wr) begin
        done_q <= 1'b0;
      end
      case (state_q)
        ST_RUN: begin
          if (go_exec) begin
            done_q    <= 1'b1;
            file_addr <= faddr;
            case (opc)
              `OP_RRF: begin
                carry_q  <= f_val[0];
                result_q <= rot_val;
                file_we    <= dsel;
                file_wdata <= rot_val;
                acc_we     <= !dsel;
                acc_wdata  <= rot_val;
              end
              `OP_LSUB: begin
                carry_q           <= sub_c;
                nibble_carry_flag <= sub_dc;
                zero_q    <= (sub_diff == 8'h00);
                result_q  <= sub_diff;
                acc_we    <= 1'b1;
                acc_wdata <= sub_diff;
              end
              `OP_FSUB, `OP_FSUBB: begin
                carry_q           <= sub_c;
                nibble_carry_flag <= sub_dc;
                zero_q     <= (sub_diff == 8'h00);
                result_q   <= sub_diff;
                file_we    <= dsel;
                file_wdata <= sub_diff;
                acc_we     <= !dsel;
                acc_wdata  <= sub_diff;
              end
              `OP_SLEEP: begin
                powerdown_status_bit <= 1'b0;
                timeout_status_bit   <= 1'b1;
                watchdog_counter <= `RST_WDT;
                presc_q          <= `RST_PRESC;
                state_q       <= ST_SLEEP;
                core_sleeping <= 1'b1;
              end
              default: begin
                done_q <= 1'b0;
              end
            endcase
          end
        end
        ST_SLEEP: begin
          if (wake_event || wake_wr) begin
            state_q       <= ST_RUN;
            core_sleeping <= 1'b0;
          end
        end
        default: begin
          // Stray state goes back to run
          state_q <= ST_RUN;
        end
      endcase
    end
  end

endmodule // rotate_subtract_sleep_exec

// File: hw/rss_exec_map.vh
// Register offsets, field positions, reset values and opcodes for the executor
`ifndef RSS_EXEC_MAP_VH
`define RSS_EXEC_MAP_VH

// Register byte offsets
`define REG_CTRL        4'h0
`define REG_OPER        4'h4
`define REG_STATUS      4'h8
`define REG_RESULT      4'hC

// Control register fields
`define CTRL_GO_BIT     0
`define CTRL_WAKE_BIT   1

// Operand register fields
`define OPER_FILE_LSB   0
`define OPER_FILE_MSB   7
`define OPER_ACC_LSB    8
`define OPER_ACC_MSB    15
`define OPER_LIT_LSB    16
`define OPER_LIT_MSB    23
`define OPER_OP_LSB     24
`define OPER_OP_MSB     26
`define OPER_DEST_BIT   27
`define OPER_ADDR_LSB   28

// Status register fields
`define STAT_C_BIT      0
`define STAT_DC_BIT     1
`define STAT_Z_BIT      2
`define STAT_PD_BIT     3
`define STAT_TO_BIT     4
`define STAT_SLEEP_BIT  5
`define STAT_DONE_BIT   6

// Operation codes
`define OP_RRF          3'h0
`define OP_LSUB         3'h1
`define OP_FSUB         3'h2
`define OP_FSUBB        3'h3
`define OP_SLEEP        3'h4

// Reset values
`define RST_OPER        32'h00000000
`define RST_STATUS      8'h18
`define RST_WDT         8'h00
`define RST_PRESC       8'h00

`endif

// File: hw/sub_unit.v
// Eight-bit subtractor with carry and nibble carry outputs
`timescale 1ns/1ps
module sub_unit (
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       cin,
  output wire [7:0] diff,
  output wire       cout,
  output wire       dcout
);
  wire [8:0] full;
  wire [4:0] low;
  // Two's complement a + ~b + cin
  assign full  = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
  assign low   = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
  assign diff  = full[7:0];
  assign cout  = full[8];
  assign dcout = low[4];
endmodule // sub_unit

// File: tb/file_space_model.sv
// Far-side file register space model
`timescale 1ns/1ps
module file_space_model (
  input wire       aclk,
  input wire       file_we,
  input wire [6:0] file_addr,
  input wire [7:0] file_wdata
);
  reg [7:0] mem_q [0:127];
  always @(posedge aclk) begin
    if (file_we) begin
      mem_q[file_addr] <= file_wdata;
    end
  end
endmodule // file_space_model

// File: tb/rotate_subtract_sleep_exec_tb.sv
// Self-checking bench for the rotate, subtract and sleep executor
`timescale 1ns/1ps
module rotate_subtract_sleep_exec_tb;
  reg         aclk = 1'h0;
  reg         aresetn = 1'h0;
  reg  [3:0]  s_axi_awaddr = 4'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg  [3:0]  s_axi_araddr = 4'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg         wake_event = 1'h0, watchdog_tick = 1'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, file_we, acc_we, core_sleeping;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  watchdog_counter, file_wdata, acc_wdata;
  wire [6:0]  file_addr;
  integer     err_total = 0, cmp_count = 0, seed = 32'h1914, i;
  reg         ec = 1'h0, edc = 1'h0, ez = 1'h0, epd = 1'h1;
  reg  [31:0] rv;
  reg  [1:0]  rr;
  reg  [15:0] exp_q [$];

  rotate_subtract_sleep_exec dut (.*);
  file_space_model partner (.*);
  always #20 aclk = ~aclk;

  task test_done;
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] want);
    cmp_count = cmp_count + 1;
    if (seen !== want) begin
      err_total = err_total + 1;
      $display("BAD %0t %h %h", $time, seen, want);
    end
  endtask
  task guard(input integer n);
    if (n >= 20) begin
      err_total = err_total + 1;
      test_done;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      n = 0;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        n = n + 1;
        if (n == 3) s_axi_bready <= 1'h1;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 20);
      s_axi_bready <= 1'h0;
      check(s_axi_bresp, r);
      guard(n);
    end
  endtask
  task rd(input [3:0] a);
    integer n;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      n = 0;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        n = n + 1;
        if (n == 3) s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 20);
      s_axi_rready <= 1'h0;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      guard(n);
    end
  endtask
  task stat(input sl, input dn);
    rd(4'h8);
    check(rv[6:0], {dn, sl, 1'h1, epd, ez, edc, ec});
  endtask
  task exec(input [2:0] op, input [7:0] f, a, k, input d, input [3:0] ad);
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] r;
    reg       w;
    begin
      s = ((op == 3'h1) ? k : f) + {1'h0, ~a} + ((op == 3'h3) ? ec : 1'h1);
      h = ((op == 3'h1) ? k[3:0] : f[3:0]) + {1'h0, ~a[3:0]}
        + ((op == 3'h3) ? ec : 1'h1);
      r = (op == 3'h0) ? {ec, f[7:1]} : s[7:0];
      w = d && (op != 3'h1);
      wr(4'h4, {ad, d, op, k, a, f}, 2'h0);
      exp_q.push_back({w, w ? {3'h0, ad} : 7'h00, r});
      wr(4'h0, 32'h1, 2'h0);
      if (op == 3'h0) ec = f[0];
      else begin
        ec = s[8];
        edc = h[4];
        ez = (r == 8'h00);
      end
      rd(4'hC);
      check(rv[7:0], r);
      stat(1'h0, 1'h1);
    end
  endtask

  // Each write pulse is matched against the oldest expected write
  always @(posedge aclk)
    if (file_we === 1'h1 || acc_we === 1'h1)
      check({file_we, file_we ? file_addr : 7'h00,
             file_we ? file_wdata : acc_wdata},
            exp_q.size() ? exp_q.pop_front() : 16'bx);

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    stat(1'h0, 1'h0);
    rd(4'h2);
    check(rr, 2'h2);
    wr(4'h6, 32'h0, 2'h2);
    exec(3'h2, 8'h5A, 8'h5A, 8'h00, 1'h1, 4'hF);
    exec(3'h3, 8'h10, 8'h20, 8'h00, 1'h0, 4'h1);
    exec(3'h3, 8'h21, 8'h20, 8'h00, 1'h1, 4'h2);
    exec(3'h1, 8'h00, 8'h0F, 8'h0F, 1'h1, 4'h3);
    watchdog_tick <= 1'h1;
    repeat (600) @(posedge aclk);
    watchdog_tick <= 1'h0;
    @(posedge aclk);
    check(watchdog_counter, 8'h02);
    wr(4'h4, 32'h04000000, 2'h0);
    wr(4'h0, 32'h1, 2'h0);
    @(posedge aclk);
    epd = 1'h0;
    check(watchdog_counter, 8'h00);
    stat(1'h1, 1'h1);
    wr(4'h4, 32'h380000FF, 2'h0);
    wr(4'h0, 32'h1, 2'h0);
    stat(1'h1, 1'h0);
    wake_event <= 1'h1;
    @(posedge aclk);
    wake_event <= 1'h0;
    repeat (2) @(posedge aclk);
    check(core_sleeping, 1'h0);
    watchdog_tick <= 1'h1;
    repeat (255) @(posedge aclk);
    watchdog_tick <= 1'h0;
    @(posedge aclk);
    check(watchdog_counter, 8'h00);
    watchdog_tick <= 1'h1;
    @(posedge aclk);
    watchdog_tick <= 1'h0;
    @(posedge aclk);
    check(watchdog_counter, 8'h01);
    wr(4'h4, 32'h04000000, 2'h0);
    wr(4'h0, 32'h1, 2'h0);
    wr(4'h0, 32'h2, 2'h0);
    @(posedge aclk);
    check(core_sleeping, 1'h0);
    wr(4'h4, 32'h05000000, 2'h0);
    wr(4'h0, 32'h1, 2'h0);
    stat(1'h0, 1'h0);
    for (i = 0; i < 40; i = i + 1) begin
      rv = $random(seed);
      exec({1'h0, i[1:0]}, rv[7:0], rv[15:8], rv[23:16], rv[24], rv[28:25]);
    end
    check(exp_q.size(), 0);
    test_done;
  end
endmodule // rotate_subtract_sleep_exec_tb

// File: tb/rss_exec_props.sv
// Port checks for the rotate, subtract and sleep executor
`timescale 1ns/1ps
module rss_exec_props (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire [7:0] watchdog_counter,
  input wire       core_sleeping,
  input wire       file_we,
  input wire       acc_we
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_one_dest;
    !(file_we && acc_we);
  endproperty
  a_one_dest: assert property (p_one_dest) else $error("two dests");
  property p_sleep_quiet;
    core_sleeping |-> !file_we && !acc_we;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("ran asleep");
  property p_wd_clear;
    $rose(core_sleeping) |-> watchdog_counter == 8'h00;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("wd kept");
  property p_we_pulse;
    file_we |=> !file_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("long write");
endmodule // rss_exec_props

bind rotate_subtract_sleep_exec rss_exec_props u_props (.*);
